/* core/vpic_arb.sv */
// fixed-order priority search over the user request lines
`timescale 1ns/1ps
`default_nettype none

module vpic_arb #(
  parameter int N = 72,
  parameter int W = 3
) (
  input wire logic [N-1:0] req,
  input wire logic [N*W-1:0] prio,
  output logic found,
  output logic [6:0] idx,
  output logic [W-1:0] lvl
);

  //////////////////////////////////////////////////////////////////////
  // search from the top down so a lower index wins every tie
  always_comb begin
    found = 1'b0;
    idx = 7'h00;
    lvl = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i] && (!found || prio[i*W +: W] >= lvl)) begin
        found = 1'b1;
        idx = 7'(i);
        lvl = prio[i*W +: W];
      end
    end
  end

endmodule // vpic_arb

`default_nettype wire

/* core/vpic_pkg.sv */
// shared constants for the vectored priority interrupt controller
package vpic_pkg;

  // source space: request numbers 0..71 map to vectors 8..79
  localparam int NIRQ = 72;
  localparam int NFW = 5;                 // flag and enable words
  localparam int NF = NFW * 16;           // flag bits incl. unused top
  localparam int NPW = 18;                // priority words, four fields each
  localparam int PW = 3;                  // priority field width
  localparam int NTRAP = 4;               // implemented traps, vectors 1..4

  // register indices on the plain register port
  localparam logic [5:0] R_CTRL1 = 6'h00;
  localparam logic [5:0] R_CTRL2 = 6'h01;
  localparam logic [5:0] R_FLAG = 6'h02;  // five words
  localparam logic [5:0] R_EN = 6'h07;    // five words
  localparam logic [5:0] R_PRIO = 6'h0c;  // eighteen words
  localparam logic [5:0] R_PEND = 6'h1e;
  localparam logic [5:0] R_STAT = 6'h1f;  // cpu_status_word
  localparam logic [5:0] R_CORE = 6'h20;  // core_control_word

  // global_control_one fields
  localparam int C1_NEST = 15;
  localparam int C1_OSC = 1;
  localparam int C1_STK = 2;
  localparam int C1_ADDR = 3;
  localparam int C1_MATH = 4;
  // global_control_two fields
  localparam int C2_ALT = 15;
  localparam int C2_POL = 0;              // three polarity bits 2:0
  // pending register fields
  localparam int PD_VEC = 0;              // 6:0
  localparam int PD_LVL = 8;              // 11:8
  // cpu words
  localparam int ST_IPL = 5;              // 7:5
  localparam int CO_PRIORITY_LEVEL_UPPER_BIT = 3;

  // vector layout
  localparam logic [6:0] VEC_USER = 7'h08;
  localparam logic [6:0] VEC_UART_ERR = 7'h49;   // vector 73, request 65
  localparam logic [23:0] TBL_PRI = 24'h000004;
  localparam logic [23:0] TBL_ALT = 24'h000104;
  localparam logic [3:0] LVL_TOP = 4'hf;   // trap level is top minus vector
  localparam logic [3:0] LVL_USER_MAX = 4'h7;

  // request numbers of the external inputs
  localparam int EXT0_IRQ = 0;
  localparam int EXT1_IRQ = 20;
  localparam int EXT2_IRQ = 29;

  // whole state of the controller
  typedef struct packed {
    logic [NF-1:0] flag;
    logic [NF-1:0] en;
    logic [NIRQ*PW-1:0] prio;
    logic nest;
    logic [NTRAP-1:0] tflag;
    logic alt;
    logic [2:0] pol;
    logic [2:0] ipl_lo;
    logic priority_level_upper_bit;
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] s3;
    logic [6:0] vec;
    logic [3:0] lvl;
    logic req;
    logic [23:0] addr;
    logic [15:0] rdata;
  } vpic_state_s;

endpackage

/* core/vpic_top.sv */
// vectored priority interrupt controller: registers, edges, arbitration
//
// Chosen here: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none

module vpic_top
  import vpic_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [5:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic [vpic_pkg::NIRQ-1:0] periph_req,
  input wire logic [2:0] ext_pin,
  input wire logic [vpic_pkg::NTRAP-1:0] trap_evt,
  input wire logic cpu_ack,
  input wire logic cpu_ret,
  input wire logic [3:0] ret_level,
  output logic irq_req,
  output logic [6:0] irq_vector,
  output logic [3:0] irq_level,
  output logic [23:0] irq_addr,
  output logic [3:0] cpu_level
);
  import vpic_pkg::*;

  //////////////////////////////////////////////////////////////////////
  // state and helpers
  vpic_state_s r;          // registered state
  vpic_state_s next_r;     // next state
  logic [3:0] cur_lvl;     // current cpu priority level
  logic [NIRQ-1:0] live;   // flagged and enabled sources
  logic [NIRQ-1:0] set_ev; // hardware set events per source
  logic [2:0] ext_ev;      // edge events on the external inputs
  logic u_found;           // a user source is live
  logic [6:0] u_idx;       // its request number
  logic [PW-1:0] u_lvl;    // its priority

  assign cur_lvl = {r.priority_level_upper_bit, r.ipl_lo};

  assign live = r.flag[NIRQ-1:0] & r.en[NIRQ-1:0];

  //////////////////////////////////////////////////////////////////////
  // edge detect on synchronised pins; s1 feeds s2 and nothing else
  // limitation: a pin pulse shorter than a clock period may go unseen
  // polarity picks edge
  assign ext_ev = (r.pol & ~r.s2 & r.s3) | (~r.pol & r.s2 & ~r.s3);

  // merge peripheral strobes with external edges by request number
  always_comb begin
    set_ev = periph_req;
    set_ev[EXT0_IRQ] = periph_req[EXT0_IRQ] | ext_ev[0];
    set_ev[EXT1_IRQ] = periph_req[EXT1_IRQ] | ext_ev[1];
    set_ev[EXT2_IRQ] = periph_req[EXT2_IRQ] | ext_ev[2];
  end

  //////////////////////////////////////////////////////////////////////
  // user arbitration
  vpic_arb #(
    .N(NIRQ),
    .W(PW)
  ) u_arb (
    .req(live),
    .prio(r.prio),
    .found(u_found),
    .idx(u_idx),
    .lvl(u_lvl)
  );

  //////////////////////////////////////////////////////////////////////
  // next-state logic: register writes, hardware sets, cpu handshake
  always_comb begin
    logic t_found;
    logic [6:0] t_vec;
    logic [3:0] t_lvl;
    logic [3:0] new_lvl;
    logic [6:0] w_vec;
    logic [3:0] w_lvl;
    logic w_ok;
    t_found = 1'b0;
    t_vec = 7'h00;
    t_lvl = 4'h0;
    new_lvl = 4'h0;
    w_vec = 7'h00;
    w_lvl = 4'h0;
    w_ok = 1'b0;
    next_r = r;

    // pin synchronisers
    next_r.s1 = ext_pin;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;

    // software writes; indices that match nothing are dropped silently
    // register set decode
    if (reg_wr) begin
      // a 1 written into a trap flag raises that trap, handy for tests
      // control one layout
      if (reg_addr == R_CTRL1) begin
        next_r.nest = reg_wdata[C1_NEST];
        next_r.tflag = {reg_wdata[C1_MATH], reg_wdata[C1_STK],
                        reg_wdata[C1_ADDR], reg_wdata[C1_OSC]};
      end
      if (reg_addr == R_CTRL2) begin
        next_r.alt = reg_wdata[C2_ALT];
        next_r.pol = reg_wdata[C2_POL +: 3];
      end
      for (int i = 0; i < NFW; i++) begin
        if (reg_addr == R_FLAG + 6'(i))
          next_r.flag[i*16 +: 16] = reg_wdata;
        if (reg_addr == R_EN + 6'(i))
          next_r.en[i*16 +: 16] = reg_wdata;
      end
      // field k sits at bits 4k+2:4k; bit 4k+3 of each nibble reads zero
      // four fields per word
      for (int i = 0; i < NPW; i++) begin
        if (reg_addr == R_PRIO + 6'(i)) begin
          for (int k = 0; k < 4; k++)
            next_r.prio[(i*4+k)*PW +: PW] = reg_wdata[k*4 +: PW];
        end
      end
      if (reg_addr == R_STAT && !r.nest)
        next_r.ipl_lo = reg_wdata[ST_IPL +: 3];
    end

    // hardware set beats clear
    // a clear written in the cycle a source fires is lost, never the event
    next_r.flag[NIRQ-1:0] = next_r.flag[NIRQ-1:0] | set_ev;
    // no sources past request 71
    // top bits of the last words have no source behind them, so they stay zero
    next_r.flag[NF-1:NIRQ] = '0;
    next_r.en[NF-1:NIRQ] = '0;
    next_r.tflag = next_r.tflag | trap_evt;

    for (int i = NTRAP - 1; i >= 0; i--) begin
      if (r.tflag[i]) begin
        t_found = 1'b1;
        t_vec = 7'(i + 1);
      end
    end
    // counting down from the top keeps every trap above any user level
    t_lvl = LVL_TOP - t_vec[3:0];

    if (t_found && t_lvl > cur_lvl) begin
      w_ok = 1'b1;
      w_vec = t_vec;
      w_lvl = t_lvl;
    end else if (u_found && {1'b0, u_lvl} > cur_lvl) begin
      // no trap above the cpu level: the arbiter's winner may go
      w_ok = 1'b1;
      w_vec = u_idx + VEC_USER;
      w_lvl = {1'b0, u_lvl};
    end

    next_r.req = w_ok;
    if (w_ok) begin
      next_r.vec = w_vec;
      next_r.lvl = w_lvl;
      next_r.addr = (r.alt ? TBL_ALT : TBL_PRI) + {16'h0000, w_vec, 1'b0};
    end

    // cpu takes the request: raise level; nesting off pins users at 7
    // an ack outranks a return that lands in the same cycle
    if (cpu_ack && r.req) begin
      new_lvl = r.lvl;
      if (r.nest && !r.lvl[3])
        new_lvl = LVL_USER_MAX;
      next_r.priority_level_upper_bit = new_lvl[3];
      next_r.ipl_lo = new_lvl[2:0];
      next_r.req = 1'b0;
    end else if (cpu_ret) begin
      // return from service restores the stacked level
      next_r.priority_level_upper_bit = ret_level[3];
      next_r.ipl_lo = ret_level[2:0];
    end

    // read data, one cycle after the strobe
    // the bus idles at zero, so a stale word never lingers on reg_rdata
    next_r.rdata = 16'h0000;
    if (reg_rd) begin
      if (reg_addr == R_CTRL1) begin
        next_r.rdata[C1_NEST] = r.nest;
        next_r.rdata[C1_OSC] = r.tflag[0];
        next_r.rdata[C1_ADDR] = r.tflag[1];
        next_r.rdata[C1_STK] = r.tflag[2];
        next_r.rdata[C1_MATH] = r.tflag[3];
      end
      if (reg_addr == R_CTRL2) begin
        next_r.rdata[C2_ALT] = r.alt;
        next_r.rdata[C2_POL +: 3] = r.pol;
      end
      for (int i = 0; i < NFW; i++) begin
        if (reg_addr == R_FLAG + 6'(i))
          next_r.rdata = r.flag[i*16 +: 16];
        if (reg_addr == R_EN + 6'(i))
          next_r.rdata = r.en[i*16 +: 16];
      end
      for (int i = 0; i < NPW; i++) begin
        if (reg_addr == R_PRIO + 6'(i)) begin
          for (int k = 0; k < 4; k++)
            next_r.rdata[k*4 +: PW] = r.prio[(i*4+k)*PW +: PW];
        end
      end
      // unmapped indices match nothing here and read as zero
      if (reg_addr == R_PEND) begin
        next_r.rdata[PD_VEC +: 7] = r.vec;
        next_r.rdata[PD_LVL +: 4] = r.lvl;
      end
      if (reg_addr == R_STAT)
        next_r.rdata[ST_IPL +: 3] = r.ipl_lo;
      if (reg_addr == R_CORE)
        next_r.rdata[CO_PRIORITY_LEVEL_UPPER_BIT] = r.priority_level_upper_bit;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // the only clocked process; synchronous reset
  // no clock enable: the whole state struct loads on every edge
  always_ff @(posedge core_clk) begin
    if (reset) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // outputs straight from the state flops
  // cpu_level is only wiring of two state fields, no gate in between
  assign reg_rdata = r.rdata;
  assign irq_req = r.req;
  assign irq_vector = r.vec;
  assign irq_level = r.lvl;
  assign irq_addr = r.addr;
  assign cpu_level = cur_lvl;

  //////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  a_flag_sets: assert property (periph_req[65] |=> r.flag[65])
    else $error("uart error strobe did not set its flag");
  a_flag_clear_sw: assert property (
    r.flag[3] && !(reg_wr && reg_addr == R_FLAG) |=> r.flag[3])
    else $error("flag dropped without a software write");
  a_enable_gate: assert property (
    r.req && r.vec == VEC_USER && !cpu_ack |-> $past(r.en[0]))
    else $error("disabled source was forwarded");
  a_above_level: assert property (
    $rose(r.req) && !r.lvl[3] |-> r.lvl > $past(cur_lvl))
    else $error("user request not above cpu level");
  a_mask_seven: assert property (
    (r.ipl_lo == 3'h7 || r.priority_level_upper_bit) |=> !(r.req && !r.lvl[3]))
    else $error("user request passed a masking level");
  a_table_addr: assert property (
    $rose(r.req) |-> r.addr[8] == $past(r.alt) && r.addr[7:0] == 8'({r.vec, 1'b0} + 8'h04))
    else $error("vector address wrong for table");
  a_nest_frozen: assert property (
    r.nest && reg_wr && reg_addr == R_STAT && !cpu_ack && !cpu_ret |=> $stable(r.ipl_lo))
    else $error("level bits written while nesting disabled");
  a_upper_ro: assert property (
    !cpu_ack && !cpu_ret |=> $stable(r.priority_level_upper_bit))
    else $error("upper level bit changed by software");
  a_nest_pin: assert property (
    cpu_ack && r.req && r.nest && !r.lvl[3] |=> cur_lvl == LVL_USER_MAX)
    else $error("nesting disable did not pin level");
  a_edge_rise: assert property (
    !r.pol[0] && !r.s3[0] && r.s2[0] |=> r.flag[EXT0_IRQ])
    else $error("rising edge missed on external zero");
  // further guards on vectors, levels, edges and the read port
  a_trap_first: assert property (
    r.tflag[0] && cur_lvl < 4'he && !cpu_ack |=> r.req && r.vec == 7'h01)
    else $error("oscillator trap not forwarded first");
  a_user_vec: assert property (
    r.req && !r.lvl[3] |-> r.vec >= VEC_USER)
    else $error("user level paired with a trap vector");
  a_ack_level: assert property (
    cpu_ack && r.req && !r.nest |=> cur_lvl == $past(r.lvl))
    else $error("taken level differs from pending level");
  a_ret_restore: assert property (
    cpu_ret && !(cpu_ack && r.req) |=> cur_lvl == $past(ret_level))
    else $error("return did not restore the level");
  a_ext_fall: assert property (
    r.pol[0] && r.s3[0] && !r.s2[0] |=> r.flag[EXT0_IRQ])
    else $error("falling edge missed on external zero");
  a_read_idle: assert property (
    !reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data without a read strobe");
  a_reserved_vec: assert property (
    r.req |-> r.vec < 7'h50)
    else $error("reserved vector forwarded");

  c_user_req: cover property ($rose(r.req) && !r.lvl[3]);
  c_trap_req: cover property ($rose(r.req) && r.lvl[3]);
  c_alt_table: cover property (r.req && r.alt);
  c_nest_ack: cover property (cpu_ack && r.nest);
  c_ext_fall: cover property (r.pol[0] && r.s3[0] && !r.s2[0]);

endmodule // vpic_top

`default_nettype wire

/* tb/vpic_cpu_model.sv */
// behavioural cpu core that takes interrupts and returns from them
`timescale 1ns/1ps
`default_nettype none

module vpic_cpu_model (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic irq_req,
  input wire logic [3:0] cpu_level,
  input wire logic [3:0] ack_delay,
  input wire logic ret_go,
  output logic cpu_ack,
  output logic cpu_ret,
  output logic [3:0] ret_level
);
  logic [3:0] wait_cnt; // cycles the request has waited
  logic [3:0] saved; // level before the last take, one deep only

  ////////////////////////////////////////////////////////////////////////
  // a slow cpu leaves the request pending for ack_delay cycles
  always_ff @(posedge core_clk) begin
    if (reset) begin
      wait_cnt <= 4'h0;
      cpu_ack <= 1'b0;
      cpu_ret <= 1'b0;
      saved <= 4'h0;
    end else begin
      cpu_ret <= ret_go;
      if (cpu_ack) begin
        cpu_ack <= 1'b0;
        wait_cnt <= 4'h0;
      end else if (irq_req) begin
        if (wait_cnt == ack_delay) begin
          cpu_ack <= 1'b1;
          saved <= cpu_level;
        end else begin
          wait_cnt <= wait_cnt + 4'h1;
        end
      end else begin
        // request withdrawn before it was taken: the next one waits afresh
        wait_cnt <= 4'h0;
      end
    end
  end

  // restore level is only qualified by cpu_ret, garbage otherwise
  assign ret_level = cpu_ret ? saved : ~saved;
endmodule // vpic_cpu_model
`default_nettype wire

/* tb/vpic_top_tb.sv */
// self-checking bench for the vectored interrupt controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin bad_count++; $display("[FAIL] %0t got %h want %h", $time, g, e); end end

module vpic_top_tb;
  import vpic_pkg::*;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [5:0] reg_addr = 6'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [NIRQ-1:0] periph_req = '0;
  logic [2:0] ext_pin = 3'h0;
  logic [NTRAP-1:0] trap_evt = '0;
  logic [3:0] ack_delay = 4'h2;
  logic ret_go = 1'b0;
  logic [15:0] reg_rdata;
  logic cpu_ack, cpu_ret, irq_req;
  logic [3:0] ret_level, irq_level, cpu_level;
  logic [6:0] irq_vector;
  logic [23:0] irq_addr;
  int bad_count = 0;
  int tests_run = 0;
  int seed = 59206;
  int cycles = 0;
  int i, k;
  logic hit, pol;
  logic [15:0] d;
  int tbit[4] = '{1, 3, 2, 4};
  int xirq[3] = '{EXT0_IRQ, EXT1_IRQ, EXT2_IRQ};
  logic [5:0] regs[9] = '{R_CTRL1, R_CTRL2, R_FLAG, R_EN, R_PRIO, R_PEND, R_STAT, R_CORE, 6'h3f};

  vpic_top DUT (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .periph_req(periph_req), .ext_pin(ext_pin),
    .trap_evt(trap_evt), .cpu_ack(cpu_ack), .cpu_ret(cpu_ret), .ret_level(ret_level), .irq_req(irq_req),
    .irq_vector(irq_vector), .irq_level(irq_level), .irq_addr(irq_addr), .cpu_level(cpu_level));
  vpic_cpu_model u_cpu (.core_clk(core_clk), .reset(reset), .irq_req(irq_req), .cpu_level(cpu_level),
    .ack_delay(ack_delay), .ret_go(ret_go), .cpu_ack(cpu_ack), .cpu_ret(cpu_ret), .ret_level(ret_level));

  ////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  always #50 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      report_and_stop();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register port master and helpers
  task automatic wr(input logic [5:0] a, input logic [15:0] v);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // read data stand in the cycle after the strobe only
  task automatic rd(input logic [5:0] a, output logic [15:0] v);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    v = reg_rdata;
  endtask
  task automatic pulse(input logic [NIRQ-1:0] m);
    @(posedge core_clk);
    periph_req <= m;
    @(posedge core_clk);
    periph_req <= '0;
  endtask
  task automatic watch(input int n, output logic h);
    h = 1'b0;
    for (int j = 0; j < n && !h; j++) begin
      @(negedge core_clk);
      h = (irq_req === 1'b1);
    end
  endtask
  task automatic wait_lvl(input logic [3:0] e);
    for (int j = 0; j < 12 && cpu_level !== e; j++) @(negedge core_clk);
  endtask
  task automatic ret(input logic [3:0] e);
    @(posedge core_clk);
    ret_go <= 1'b1;
    @(posedge core_clk);
    ret_go <= 1'b0;
    wait_lvl(e);
    `CHK(cpu_level, e)
  endtask
  // table address of a vector, alternate table one page up
  function automatic logic [23:0] vaddr(input logic [6:0] v, input logic a);
    return TBL_PRI + {16'h0, v, 1'b0} + (a ? 24'h000100 : 24'h000000);
  endfunction
  task automatic report_and_stop;
    if (bad_count == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // one user source served end to end and cleaned up
  task automatic serve(input int n, input logic [2:0] p, input logic a);
    logic [6:0] v;
    v = VEC_USER + 7'(n);
    wr(R_CTRL2, {a, 15'h0000});
    wr(R_EN + 6'(n / 16), 16'h0001 << (n % 16));
    wr(R_PRIO + 6'(n / 4), 16'(p) << (4 * (n % 4)));
    pulse(NIRQ'(1) << n);
    watch(12, hit);
    `CHK(hit, 1'b1)
    `CHK(irq_vector, v)
    `CHK(irq_level, {1'b0, p})
    `CHK(irq_addr, vaddr(v, a))
    rd(R_PEND, d);
    `CHK(d, {5'h00, p, 1'b0, v})
    wait_lvl({1'b0, p});
    `CHK(cpu_level, {1'b0, p})
    rd(R_FLAG + 6'(n / 16), d);
    `CHK(d[n % 16], 1'b1)
    wr(R_FLAG + 6'(n / 16), 16'h0000);
    wr(R_EN + 6'(n / 16), 16'h0000);
    wr(R_PRIO + 6'(n / 4), 16'h0000);
    ret(4'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (5) @(posedge core_clk);
    reset <= 1'b0;
    // reset contents, unmapped index last
    foreach (regs[j]) begin
      rd(regs[j], d);
      `CHK(d, 16'h0000)
    end
    wr(R_CTRL2, 16'hffff);
    rd(R_CTRL2, d);
    `CHK(d, 16'h8007)
    // corner sources, then random ones with a random cpu speed
    serve(0, 3'h1, 1'b0);
    serve(65, 3'h7, 1'b1);
    serve(71, 3'h4, 1'b1);
    for (i = 0; i < 12; i++) begin
      ack_delay <= 4'(1 + $unsigned($random(seed)) % 6);
      serve($unsigned($random(seed)) % NIRQ, 3'(1 + $unsigned($random(seed)) % 7), 1'($random(seed)));
    end
    // masking by level, upper bit locked
    ack_delay <= 4'hf;
    wr(R_STAT, 16'h00a0);
    rd(R_STAT, d);
    `CHK(d, 16'h00a0)
    wr(R_CORE, 16'h0008);
    @(negedge core_clk);
    `CHK(cpu_level, 4'h5)
    rd(R_CORE, d);
    `CHK(d, 16'h0000)
    wr(R_EN, 16'h0008);
    wr(R_PRIO, 16'h5000);
    pulse(NIRQ'(8));
    watch(8, hit);
    `CHK(hit, 1'b0)
    wr(R_PRIO, 16'h6000);
    watch(8, hit);
    `CHK(hit, 1'b1)
    wr(R_STAT, 16'h00e0);
    repeat (2) @(negedge core_clk);
    `CHK(irq_req, 1'b0)
    wr(R_EN, 16'h0000);
    wr(R_STAT, 16'h0000);
    watch(8, hit);
    `CHK(hit, 1'b0)
    wr(R_FLAG, 16'h0000);
    // equal priority, lower request wins
    ack_delay <= 4'h2;
    wr(R_EN, 16'h0006);
    wr(R_PRIO, 16'h0440);
    pulse(NIRQ'(6));
    watch(12, hit);
    `CHK(irq_vector, 7'h09)
    wait_lvl(4'h4);
    `CHK(cpu_level, 4'h4)
    wr(R_FLAG, 16'h0000);
    ret(4'h0);
    // nesting disabled: level locked, no preemption
    wr(R_CTRL1, 16'h8000);
    rd(R_CTRL1, d);
    `CHK(d, 16'h8000)
    wr(R_STAT, 16'h0060);
    rd(R_STAT, d);
    `CHK(d, 16'h0000)
    wr(R_EN, 16'h0018);
    wr(R_PRIO, 16'h3000);
    wr(R_PRIO + 6'h01, 16'h0006);
    pulse(NIRQ'(8));
    wait_lvl(4'h7);
    `CHK(cpu_level, 4'h7)
    pulse(NIRQ'(16));
    watch(8, hit);
    `CHK(hit, 1'b0)
    wr(R_EN, 16'h0000);
    wr(R_FLAG, 16'h0000);
    wr(R_CTRL1, 16'h0000);
    ret(4'h0);
    // traps pass a level-seven cpu, both tables
    wr(R_STAT, 16'h00e0);
    for (k = 0; k < NTRAP; k++) begin
      wr(R_CTRL2, {k[0], 15'h0000});
      @(posedge core_clk);
      trap_evt <= NTRAP'(1) << k;
      @(posedge core_clk);
      trap_evt <= '0;
      watch(12, hit);
      `CHK(irq_vector, 7'(k + 1))
      `CHK(irq_level, 4'(14 - k))
      `CHK(irq_addr, vaddr(7'(k + 1), k[0]))
      rd(R_CTRL1, d);
      `CHK(d[tbit[k]], 1'b1)
      wait_lvl(4'(14 - k));
      wr(R_CTRL1, 16'h0000);
      ret(4'h7);
    end
    wr(R_STAT, 16'h0000);
    // external inputs: chosen edge sets the flag, the other does not
    for (k = 0; k < 3; k++) begin
      pol = 1'($random(seed)) ^ k[0];
      wr(R_CTRL2, 16'(pol) << k);
      ext_pin[k] <= pol;
      repeat (6) @(posedge core_clk);
      wr(R_FLAG + 6'(xirq[k] / 16), 16'h0000);
      ext_pin[k] <= ~pol;
      repeat (6) @(posedge core_clk);
      rd(R_FLAG + 6'(xirq[k] / 16), d);
      `CHK(d[xirq[k] % 16], 1'b1)
      wr(R_FLAG + 6'(xirq[k] / 16), 16'h0000);
      ext_pin[k] <= pol;
      repeat (6) @(posedge core_clk);
      rd(R_FLAG + 6'(xirq[k] / 16), d);
      `CHK(d[xirq[k] % 16], 1'b0)
    end
    report_and_stop();
  end
endmodule // vpic_top_tb
`default_nettype wire
